/* design/stepper_consts.vh */
// constants for the stepper switch-configuration and mode-control block
// assumes a 250 MHz aclk; included by bare name from design/
`ifndef STEPPER_CONSTS_VH
`define STEPPER_CONSTS_VH

// clock and times
`define CLK_MHZ             250
`define IDLE_TIME_MS        400
`define IDLE_CYCLES         (`IDLE_TIME_MS * `CLK_MHZ * 1000)
`define SELFTEST_WINDOW_MS  1000
`define SELFTEST_CYCLES     (`SELFTEST_WINDOW_MS * `CLK_MHZ * 1000)
`define DEBOUNCE_TIME_US    1000
`define DEBOUNCE_CYCLES     (`DEBOUNCE_TIME_US * `CLK_MHZ)

// register byte offsets
`define ADDR_SOFT_CURRENT   8'h00
`define ADDR_SOFT_MICROSTEP 8'h04
`define ADDR_STATUS         8'h08
`define ADDR_CURRENT_CMD    8'h0c
`define ADDR_IRQ_STATUS     8'h10
`define ADDR_IRQ_ENABLE     8'h14
`define ADDR_IRQ_CLEAR      8'h18

// reset values
`define SOFT_CURRENT_RST    7'h14
`define SOFT_MICROSTEP_RST  16'h0190
`define IRQ_ENABLE_RST      4'h0

// interrupt bit positions
`define IRQ_FAULT           0
`define IRQ_SELFTEST        1
`define IRQ_IDLE            2
`define IRQ_MODE            3

// mode codes, {mode_select_bit1, mode_select_bit0}, 1 = switch on
`define MODE_PULSE_DIR      2'b00
`define MODE_EXT_KNOB       2'b01
`define MODE_LOW_HIGH       2'b10
`define MODE_ANALOG         2'b11

// fixed peak currents in tenths of an ampere
`define CUR_26              7'h1a
`define CUR_34              7'h22
`define CUR_40              7'h28
`define CUR_48              7'h30
`define CUR_54              7'h36
`define CUR_61              7'h3d
`define CUR_70              7'h46

// fixed microstep resolutions in steps per revolution
`define USTEP_400           16'h0190
`define USTEP_1600          16'h0640
`define USTEP_12800         16'h3200

// standstill current fraction, percent
`define IDLE_PCT            10'h03c
`define PCT_DIV             10'h064

// axi answers
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

/* design/switch_debounce.v */
// two-flop synchroniser and debouncer for a group of switch pins
// assumes raw inputs asynchronous to aclk; output changes only after a steady spell
`timescale 1ns/1ns
`default_nettype none
module switch_debounce #(
	parameter WIDTH  = 8,
	parameter CYCLES = 250000
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] raw,
	output reg  [WIDTH-1:0] stable
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	reg [WIDTH-1:0] last_reg;
	reg [31:0]      count_reg;

	// synchronise, then take the value once it held still for CYCLES cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg  <= {WIDTH{1'b0}};
			sync_reg  <= {WIDTH{1'b0}};
			last_reg  <= {WIDTH{1'b0}};
			count_reg <= 32'h0;
			stable    <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= raw;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			if (sync_reg != last_reg) begin
				count_reg <= 32'h0; // bounce restarts the spell
			end else if (count_reg < CYCLES) begin
				count_reg <= count_reg + 32'h1;
			end else begin
				stable <= sync_reg;
			end
		end
	end
endmodule
`default_nettype wire

/* design/stepper_mode_ctrl.v */
// switch decode, operating-mode control, idle current, self-test and fault latch
// assumes knob and analog values come digitised from logic on aclk; pins are asynchronous
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "stepper_consts.vh"

module stepper_mode_ctrl #(
	parameter IDLE_CYCLES     = `IDLE_CYCLES,
	parameter SELFTEST_CYCLES = `SELFTEST_CYCLES,
	parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  switch_raw,
	input  wire        step_pulse_in,
	input  wire        dir_in,
	input  wire        speed_select_in,
	input  wire        fault_in,
	input  wire [7:0]  accel_ramp_knob,
	input  wire [7:0]  decel_lowspeed_knob,
	input  wire [7:0]  top_speed_knob,
	input  wire [7:0]  analog_speed_in,
	input  wire [7:0]  external_knob_in,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [6:0]  current_cmd,
	output reg  [15:0] steps_per_rev,
	output reg  [1:0]  op_mode,
	output reg  [7:0]  target_speed,
	output reg         target_dir,
	output reg  [7:0]  accel_rate,
	output reg  [7:0]  decel_rate,
	output reg         microstep_pulse,
	output reg         motor_energize,
	output reg         selftest_start,
	output reg         red_led,
	output reg         green_led,
	output wire        irq
);
	// scale a speed by the maximum-speed knob
	function [7:0] scale_speed;
		input [7:0] value;
		input [7:0] limit;
		reg   [15:0] prod;
		begin
			prod        = value * limit;
			scale_speed = prod[15:8];
		end
	endfunction

	wire [7:0] sw;
	wire [2:0] current_select = sw[2:0];
	wire       idle_reduce_selftest_switch = sw[3];
	wire [1:0] microstep_select = sw[5:4];
	wire [1:0] mode_select = sw[7:6];

	reg  [6:0]  soft_current_reg;
	reg  [15:0] soft_microstep_reg;
	reg  [3:0]  irq_status_reg;
	reg  [3:0]  irq_enable_reg;
	reg  [2:0]  pin_meta_reg;
	reg  [2:0]  pin_sync_reg;
	reg         fault_meta_reg;
	reg         fault_sync_reg;
	reg         step_last_reg;
	reg         fault_reg;
	reg         reduced_reg;
	reg  [31:0] idle_count_reg;
	reg         toggle_last_reg;
	reg         toggle_pend_reg;
	reg  [31:0] window_count_reg;
	reg  [1:0]  mode_last_reg;

	// switch pins pass two flops and a debounce before decode
	switch_debounce #(
		.WIDTH  (8),
		.CYCLES (DEBOUNCE_CYCLES)
	) u_switch_debounce (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (switch_raw),
		.stable  (sw)
	);

	// command pins: step, direction, speed select, fault
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_reg   <= 3'h0;
			pin_sync_reg   <= 3'h0;
			fault_meta_reg <= 1'b0;
			fault_sync_reg <= 1'b0;
			step_last_reg  <= 1'b0;
		end else begin
			pin_meta_reg   <= {speed_select_in, dir_in, step_pulse_in};
			pin_sync_reg   <= pin_meta_reg;
			fault_meta_reg <= fault_in;
			fault_sync_reg <= fault_meta_reg;
			step_last_reg  <= pin_sync_reg[0];
		end
	end

	wire step_edge = pin_sync_reg[0] & ~step_last_reg;
	wire dir_sync  = pin_sync_reg[1];
	wire speed_sel = pin_sync_reg[2];

	// run current and microstep decode
	reg [6:0]  run_current;
	reg [15:0] ustep_next;
	always @* begin
		case (current_select)
			3'b000: run_current = soft_current_reg;
			3'b001: run_current = `CUR_26;
			3'b010: run_current = `CUR_34;
			3'b011: run_current = `CUR_40;
			3'b100: run_current = `CUR_48;
			3'b101: run_current = `CUR_54;
			3'b110: run_current = `CUR_61;
			default: run_current = `CUR_70;
		endcase
		case (microstep_select)
			2'b11: ustep_next = soft_microstep_reg;
			2'b10: ustep_next = `USTEP_400;
			2'b01: ustep_next = `USTEP_1600;
			default: ustep_next = `USTEP_12800;
		endcase
	end

	// per-mode speed, direction and knob meaning
	reg [7:0] speed_next;
	reg       dir_next;
	reg [7:0] accel_next;
	reg [7:0] decel_next;
	reg [7:0] ext_mag;
	always @* begin
		ext_mag    = 8'h00;
		speed_next = 8'h00;
		dir_next   = dir_sync;
		accel_next = accel_ramp_knob;
		decel_next = decel_lowspeed_knob;
		case (mode_select)
			`MODE_ANALOG: begin
				speed_next = scale_speed(analog_speed_in, top_speed_knob);
			end
			`MODE_LOW_HIGH: begin
				speed_next = speed_sel ? top_speed_knob : decel_lowspeed_knob;
				decel_next = accel_ramp_knob;
			end
			`MODE_EXT_KNOB: begin
				if (external_knob_in[7]) begin
					ext_mag  = {external_knob_in[6:0], 1'b1};
					dir_next = 1'b1;
				end else begin
					ext_mag  = {~external_knob_in[6:0], 1'b1};
					dir_next = 1'b0;
				end
				speed_next = scale_speed(ext_mag, top_speed_knob);
			end
			default: begin
				accel_next = 8'h00;
				decel_next = 8'h00;
			end
		endcase
	end

	wire pulse_mode = (mode_select == `MODE_PULSE_DIR);
	wire step_cmd   = pulse_mode ? step_edge : (speed_next != 8'h00);
	// 7.0 A times 60 reaches 4200, so the product needs 13 bits
	wire [12:0] idle_prod = {6'h00, run_current} * {3'h0, `IDLE_PCT};
	wire [12:0] idle_cur  = idle_prod / {3'h0, `PCT_DIV};
	wire toggled = (idle_reduce_selftest_switch != toggle_last_reg);
	wire trigger = toggled & toggle_pend_reg;

	// registered motion outputs, idle timer, fault latch, self-test detect
	always @(posedge aclk) begin
		if (!aresetn) begin
			current_cmd      <= 7'h00;
			steps_per_rev    <= `USTEP_12800;
			op_mode          <= `MODE_PULSE_DIR;
			target_speed     <= 8'h00;
			target_dir       <= 1'b0;
			accel_rate       <= 8'h00;
			decel_rate       <= 8'h00;
			microstep_pulse  <= 1'b0;
			motor_energize   <= 1'b0;
			red_led          <= 1'b0;
			green_led        <= 1'b0;
			fault_reg        <= 1'b0;
			reduced_reg      <= 1'b0;
			idle_count_reg   <= 32'h0;
			toggle_last_reg  <= 1'b0;
			toggle_pend_reg  <= 1'b0;
			window_count_reg <= 32'h0;
			selftest_start   <= 1'b0;
			mode_last_reg    <= `MODE_PULSE_DIR;
		end else begin
			green_led       <= 1'b1;
			steps_per_rev   <= ustep_next;
			op_mode         <= mode_select;
			mode_last_reg   <= mode_select;
			target_speed    <= speed_next;
			target_dir      <= dir_next;
			accel_rate      <= accel_next;
			decel_rate      <= decel_next;
			microstep_pulse <= pulse_mode & step_edge & ~fault_reg;
			if (fault_sync_reg) begin
				fault_reg <= 1'b1;
			end
			red_led        <= fault_reg | fault_sync_reg;
			motor_energize <= ~(fault_reg | fault_sync_reg);
			// standstill timer restarts on every step command
			if (step_cmd) begin
				idle_count_reg <= 32'h0;
				reduced_reg    <= 1'b0;
			end else if (idle_count_reg < IDLE_CYCLES) begin
				idle_count_reg <= idle_count_reg + 32'h1;
			end else begin
				reduced_reg <= idle_reduce_selftest_switch;
			end
			if (fault_reg | fault_sync_reg) begin
				current_cmd <= 7'h00;
			end else if (reduced_reg) begin
				current_cmd <= idle_cur[6:0];
			end else begin
				current_cmd <= run_current;
			end
			// two changes of the standstill switch within the window
			toggle_last_reg <= idle_reduce_selftest_switch;
			selftest_start  <= trigger & ~fault_reg;
			if (trigger) begin
				toggle_pend_reg  <= 1'b0;
				window_count_reg <= 32'h0;
			end else if (toggled) begin
				toggle_pend_reg  <= 1'b1;
				window_count_reg <= 32'h0;
			end else if (toggle_pend_reg) begin
				if (window_count_reg >= SELFTEST_CYCLES - 1) begin
					toggle_pend_reg <= 1'b0;
				end else begin
					window_count_reg <= window_count_reg + 32'h1;
				end
			end
		end
	end

	// interrupt events
	wire [3:0] irq_event;
	assign irq_event[`IRQ_FAULT]    = fault_sync_reg & ~fault_reg;
	assign irq_event[`IRQ_SELFTEST] = trigger;
	assign irq_event[`IRQ_IDLE]     = ~step_cmd & ~reduced_reg & idle_reduce_selftest_switch &
	                                  (idle_count_reg >= IDLE_CYCLES);
	assign irq_event[`IRQ_MODE]     = (mode_select != mode_last_reg);
	assign irq = |(irq_status_reg & irq_enable_reg);

	// axi write side: address and data are taken in either order
	reg        aw_full_reg;
	reg        w_full_reg;
	reg [7:0]  aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
	wire do_write = aw_full_reg & w_full_reg;
	wire [3:0] irq_clear = (do_write && aw_addr_reg == `ADDR_IRQ_CLEAR && w_strb_reg[0]) ?
	                       w_data_reg[3:0] : 4'h0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg        <= 1'b0;
			w_full_reg         <= 1'b0;
			aw_addr_reg        <= 8'h00;
			w_data_reg         <= 32'h0;
			w_strb_reg         <= 4'h0;
			s_axi_bvalid       <= 1'b0;
			s_axi_bresp        <= `RESP_OKAY;
			soft_current_reg   <= `SOFT_CURRENT_RST;
			soft_microstep_reg <= `SOFT_MICROSTEP_RST;
			irq_enable_reg     <= `IRQ_ENABLE_RST;
			irq_status_reg     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				if (aw_addr_reg == `ADDR_SOFT_CURRENT) begin
					if (w_strb_reg[0]) soft_current_reg <= w_data_reg[6:0];
				end else if (aw_addr_reg == `ADDR_SOFT_MICROSTEP) begin
					if (w_strb_reg[0]) soft_microstep_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) soft_microstep_reg[15:8] <= w_data_reg[15:8];
				end else if (aw_addr_reg == `ADDR_IRQ_ENABLE) begin
					if (w_strb_reg[0]) irq_enable_reg <= w_data_reg[3:0];
				end else if (aw_addr_reg == `ADDR_STATUS || aw_addr_reg == `ADDR_CURRENT_CMD ||
				             aw_addr_reg == `ADDR_IRQ_STATUS || aw_addr_reg == `ADDR_IRQ_CLEAR) begin
					s_axi_bresp <= `RESP_OKAY; // read-only writes ignored, clear handled below
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// a new event wins over a clear in the same cycle
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
		end
	end

	// axi read side: one cycle to the answer
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			if (s_axi_araddr == `ADDR_SOFT_CURRENT) begin
				s_axi_rdata <= {25'h0, soft_current_reg};
			end else if (s_axi_araddr == `ADDR_SOFT_MICROSTEP) begin
				s_axi_rdata <= {16'h0, soft_microstep_reg};
			end else if (s_axi_araddr == `ADDR_STATUS) begin
				s_axi_rdata <= {8'h0, target_speed, 5'h0, target_dir, fault_reg, reduced_reg,
				                mode_select, microstep_select, idle_reduce_selftest_switch, current_select};
			end else if (s_axi_araddr == `ADDR_CURRENT_CMD) begin
				s_axi_rdata <= {9'h0, steps_per_rev, current_cmd};
			end else if (s_axi_araddr == `ADDR_IRQ_STATUS) begin
				s_axi_rdata <= {28'h0, irq_status_reg};
			end else if (s_axi_araddr == `ADDR_IRQ_ENABLE) begin
				s_axi_rdata <= {28'h0, irq_enable_reg};
			end else if (s_axi_araddr == `ADDR_IRQ_CLEAR) begin
				s_axi_rdata <= 32'h0; // write-only
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* dv/stepper_mode_ctrl_sva.sv */
// checker for decode, fault latch, indicator and step outputs
// sees only top-level ports; attached by the bind below
`timescale 1ns/1ns
`default_nettype none
`include "stepper_consts.vh"
module stepper_mode_ctrl_sva (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       fault_in,
	input wire logic       step_pulse_in,
	input wire logic       dir_in,
	input wire logic       speed_select_in,
	input wire logic [7:0] decel_lowspeed_knob,
	input wire logic [7:0] top_speed_knob,
	input wire logic [1:0] op_mode,
	input wire logic [7:0] target_speed,
	input wire logic       target_dir,
	input wire logic       microstep_pulse,
	input wire logic       motor_energize,
	input wire logic       selftest_start,
	input wire logic       red_led,
	input wire logic       green_led,
	input wire logic [6:0] current_cmd
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	localparam logic [1:0] PD = `MODE_PULSE_DIR;
	localparam logic [1:0] LH = `MODE_LOW_HIGH;
	// fault latches and frees the shaft
	AST_RED_HOLD: assert property (red_led |=> red_led) else $error("red indicator dropped");
	AST_FAULT_SETS: assert property ($rose(fault_in) |-> ##[1:5] red_led) else $error("fault not latched");
	AST_SHAFT_FREE: assert property (
		red_led |-> ##1 (!motor_energize && current_cmd == 7'h00)) else $error("motor still driven on fault");
	// powered indicator
	AST_GREEN_ON: assert property ($past(aresetn) |-> green_led) else $error("green indicator off");
	// pulse/direction mode
	AST_STEP_ECHO: assert property (
		($rose(step_pulse_in) && op_mode == PD && !red_led) |-> ##[2:4] microstep_pulse)
		else $error("step pulse not passed on");
	AST_PD_NO_SPEED: assert property ((op_mode == PD)[*3] |-> target_speed == 8'h00)
		else $error("speed set in pulse mode");
	AST_DIR_FOLLOW: assert property (
		(op_mode == PD && !red_led && $stable(dir_in))[*6] |-> target_dir == dir_in)
		else $error("direction not followed");
	// low/high preset pick
	AST_LOWHIGH_PICK: assert property (
		(op_mode == LH && !red_led && $stable(speed_select_in) && $stable(top_speed_knob)
		&& $stable(decel_lowspeed_knob))[*6] |-> target_speed == (speed_select_in ? top_speed_knob : decel_lowspeed_knob))
		else $error("preset speed not selected");
	AST_SELFTEST_ONE: assert property (selftest_start |=> !selftest_start[*3]) else $error("self-test repeated");
	COV_STEP: cover property (microstep_pulse);
	COV_SELFTEST: cover property (selftest_start);
	COV_FAULT: cover property ($rose(red_led));
endmodule
bind stepper_mode_ctrl stepper_mode_ctrl_sva chk_i (.*);
`default_nettype wire

/* dv/stepper_commander.sv */
// pulse/direction commander and shaft position model
// assumes one aclk domain; send is called after a rising edge
`timescale 1ns/1ns
`default_nettype none
module stepper_commander (
	input wire logic        aclk,
	input wire logic        microstep_pulse,
	input wire logic        target_dir,
	input wire logic        motor_energize,
	output var logic        step_out,
	output var logic        dir_out,
	output var logic [15:0] position
);
	initial begin
		step_out = 1'b0;
		dir_out = 1'b0;
		position = 16'h0000;
	end
	// shaft moves one microstep per pulse only while energized
	always @(posedge aclk) begin
		if (microstep_pulse && motor_energize)
			position <= target_dir ? position + 16'h0001 : position - 16'h0001;
	end
	// direction settles before the first pulse; gap sets pulse rate
	task automatic send(input int n, input logic d, input int gap);
		dir_out <= d;
		repeat (4) @(posedge aclk);
		repeat (n) begin
			step_out <= 1'b1;
			repeat (gap) @(posedge aclk);
			step_out <= 1'b0;
			repeat (gap) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the switch decode and mode control block
// short counts: idle 50, self-test window 100, debounce 4 cycles
`timescale 1ns/1ns
`default_nettype none
`include "stepper_consts.vh"
module tb;
	logic aclk, aresetn, step_pulse_in, dir_in, speed_select_in, fault_in, irq, target_dir;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, microstep_pulse;
	logic motor_energize, selftest_start, red_led, green_led;
	logic [7:0] switch_raw, accel_ramp_knob, decel_lowspeed_knob, top_speed_knob, analog_speed_in;
	logic [7:0] external_knob_in, s_axi_awaddr, s_axi_araddr, target_speed, accel_rate, decel_rate;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode, rs;
	logic [6:0]  current_cmd;
	logic [15:0] steps_per_rev, position;
	int n_errors = 0, cmp_count = 0, n_st = 0;
	logic [6:0]  cur [8] = '{7'h20, `CUR_26, `CUR_34, `CUR_40, `CUR_48, `CUR_54, `CUR_61, `CUR_70};
	logic [15:0] us [4] = '{`USTEP_12800, `USTEP_1600, `USTEP_400, 16'h0320};
	stepper_mode_ctrl #(.IDLE_CYCLES(50), .SELFTEST_CYCLES(100), .DEBOUNCE_CYCLES(4)) uut (.*);
	stepper_commander cmdr (.aclk(aclk), .microstep_pulse(microstep_pulse), .target_dir(target_dir),
		.motor_energize(motor_energize), .step_out(step_pulse_in), .dir_out(dir_in), .position(position));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// count self-test launches
	always @(posedge aclk) begin
		if (aresetn && selftest_start) n_st <= n_st + 1;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic hang(input int i);
		if (i >= 64) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	// bus write: address and data offered together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ha, hw, hb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(negedge aclk);
			ha = s_axi_awready;
			hw = s_axi_wready;
			hb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) break;
		end
		s_axi_bready <= 1'b0;
		hang(i);
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a);
		int i;
		logic h, hb;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(negedge aclk);
			h = s_axi_arready;
			hb = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (h) s_axi_arvalid <= 1'b0;
			if (hb) break;
		end
		s_axi_rready <= 1'b0;
		hang(i);
		@(posedge aclk);
	endtask
	task automatic setsw(input logic [7:0] v);
		switch_raw <= v;
		repeat (14) @(posedge aclk);
	endtask
	task automatic t_regs;
		axr(`ADDR_SOFT_CURRENT);
		chk("soft_cur", rd, 32'h14);
		axr(`ADDR_SOFT_MICROSTEP);
		chk("soft_ustep", rd, 32'h190);
		axr(8'h40);
		chk("unmapped", {rs, rd[29:0]}, {`RESP_SLVERR, 30'h0});
		axw(`ADDR_SOFT_CURRENT, 32'h20);
		axw(`ADDR_SOFT_MICROSTEP, 32'h320);
		axw(`ADDR_CURRENT_CMD, 32'hffffffff);
		axr(`ADDR_CURRENT_CMD);
		chk("cur_cmd_reg", rd, {9'h0, `USTEP_12800, 7'h20});
	endtask
	task automatic t_decode;
		for (int i = 0; i < 8; i++) begin
			setsw(i[7:0]);
			chk("current", current_cmd, cur[i]);
		end
		for (int i = 0; i < 4; i++) begin
			setsw({2'b00, i[1:0], 4'h0});
			chk("ustep", steps_per_rev, us[i]);
		end
	endtask
	task automatic t_modes;
		setsw({`MODE_ANALOG, 6'h00});
		chk("mode_an", {op_mode, target_speed, accel_rate, decel_rate}, {`MODE_ANALOG, 24'h201122});
		setsw({`MODE_EXT_KNOB, 6'h00});
		chk("mode_ext", {op_mode, target_dir, target_speed}, {`MODE_EXT_KNOB, 9'h140});
		external_knob_in <= 8'h10;
		repeat (5) @(posedge aclk);
		chk("ext_low", {target_dir, target_speed}, 9'h06f);
		setsw({`MODE_LOW_HIGH, 6'h00});
		chk("mode_lh", {op_mode, target_speed, accel_rate, decel_rate}, {`MODE_LOW_HIGH, 24'h221111});
		speed_select_in <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("lh_high", target_speed, 8'h80);
		setsw({`MODE_PULSE_DIR, 6'h00});
		chk("mode_pd", {op_mode, target_speed, accel_rate}, {`MODE_PULSE_DIR, 16'h0});
	endtask
	task automatic t_pulse;
		top_speed_knob <= 8'hff;
		cmdr.send(5, 1'b1, 2);
		cmdr.send(3, 1'b0, 5);
		repeat (8) @(posedge aclk);
		chk("position", position, 16'h0002);
		chk("pd_state", {target_dir, target_speed}, 9'h000);
	endtask
	task automatic t_selftest;
		setsw(8'h08);
		setsw(8'h00);
		chk("selftests", n_st, 1);
	endtask
	task automatic t_idle;
		setsw(8'h0f);
		axw(`ADDR_IRQ_ENABLE, 32'h4);
		cmdr.send(1, 1'b1, 2);
		repeat (6) @(posedge aclk);
		chk("run_cur", current_cmd, `CUR_70);
		repeat (60) @(posedge aclk);
		chk("idle_cur", {current_cmd, irq}, {7'd42, 1'b1});
		axw(`ADDR_IRQ_ENABLE, 32'h0);
		chk("irq_masked", irq, 1'b0);
		axw(`ADDR_IRQ_ENABLE, 32'h4);
		axw(`ADDR_IRQ_CLEAR, 32'h4);
		chk("irq_clr", irq, 1'b0);
		axr(`ADDR_IRQ_STATUS);
		chk("irq_status", rd & 32'h6, 32'h2);
		repeat (40) @(posedge aclk);
		setsw(8'h07);
		chk("full_cur", current_cmd, `CUR_70);
		chk("selftests", n_st, 1);
	endtask
	task automatic t_fault;
		chk("energized", motor_energize, 1'b1);
		fault_in <= 1'b1;
		repeat (4) @(posedge aclk);
		fault_in <= 1'b0;
		repeat (20) @(posedge aclk);
		chk("fault", {red_led, motor_energize, current_cmd}, {2'b10, 7'h00});
		chk("green", green_led, 1'b1);
		axr(`ADDR_IRQ_STATUS);
		chk("irq_fault_mode", rd & 32'h9, 32'h9);
		axr(`ADDR_STATUS);
		chk("status_fault", rd & 32'h200, 32'h200);
	endtask
	initial begin
		{aresetn, speed_select_in, fault_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, switch_raw} = '0;
		s_axi_wstrb = 4'hf;
		{accel_ramp_knob, decel_lowspeed_knob, top_speed_knob} = 24'h112280;
		{analog_speed_in, external_knob_in} = 16'h40c0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_decode;
		t_modes;
		t_pulse;
		t_selftest;
		t_idle;
		t_fault;
		tally_and_finish;
	end
endmodule
`default_nettype wire
